/* File: inc/tmc_pkg.sv */
package tmc_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_COUNT = 12'h000;
	localparam logic [11:0] ADDR_OPTION = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00C;
	localparam logic [11:0] ADDR_CTRL = 12'h010;

	// ----------------------------------------------------------------
	// Option register fields
	// ----------------------------------------------------------------
	localparam int OPT_RATIO_LSB = 0;
	localparam int OPT_ASSIGN_BIT = 3;
	localparam int OPT_SE_BIT = 4;
	localparam int OPT_CS_BIT = 5;
	localparam logic [7:0] OPTION_RESET = 8'h3F;

	// Status / mask / control fields
	localparam int STAT_OVF_BIT = 0;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic SLEEP_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PER_NS = 10;
	localparam int INSTR_PHASES = 4;
	localparam int WRITE_HOLD_CYC = 2;
	localparam int PRESC_W = 8;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} tmc_phase_t;
endpackage

/* File: inc/tmc_tick_if.sv */
`timescale 1ns/1ps
// Tick path from the prescaler to the counter core
interface tmc_tick_if;
	logic tick;
	logic clear;
	modport src (output tick, input clear);
	modport dst (input tick, output clear);
endinterface

/* File: hdl/tmc_prescaler.sv */
`timescale 1ns/1ps
module tmc_prescaler #(
	parameter int WIDTH = tmc_pkg::PRESC_W
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic src_pulse,
	input wire logic to_timer,
	input wire logic [2:0] ratio,
	tmc_tick_if.src tk
);
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic [WIDTH-1:0] cnt_inc;
	logic tap;
	logic tap_r;

	// ----------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------
	// Bit n toggles at 1:2^(n+1); ratio picks the tap
	assign cnt_inc = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
	assign cnt_nxt = tk.clear ? '0 : (src_pulse ? cnt_inc : cnt_r);
	assign tap = cnt_r[ratio];
	// Falling tap edge marks one divided period; bypass gives 1:1
	assign tk.tick = to_timer ? (tap_r & ~tap) : src_pulse;

	// Counter is internal only, never exposed on the bus
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			tap_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tap_r <= tk.clear ? 1'b0 : tap;
		end
	end
endmodule

/* File: hdl/tmc_edge_sync.sv */
`timescale 1ns/1ps
module tmc_edge_sync
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	input wire logic sample_en,
	input wire logic falling,
	output logic edge_pulse
);
	logic s1_r;
	logic s2_r;
	logic held_r;

	// ----------------------------------------------------------------
	// Two-stage synchroniser, then sampling on chosen phases
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			held_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			if (sample_en)
				held_r <= s2_r;
		end
	end

	// Edge seen between two sample points
	assign edge_pulse = sample_en &
		(falling ? (held_r & ~s2_r) : (~held_r & s2_r));
endmodule

/* File: hdl/tmc_timer8.sv */
`timescale 1ns/1ps
// Function
// - The 8-bit count register is readable and writable and serves as timer or counter.
// - With clock source select clear the count advances each instruction cycle, divided by the prescaler while it is assigned to the timer.
// - A write to the count register blocks counting for the next two instruction cycles.
// - In counter mode the count follows the external input edge set by source edge select.
// - One prescaler serves timer or watchdog; prescaler assign clear gives it to the timer.
// - Assigned to the timer the prescaler gives eight ratios from 1:2 to 1:256.
// - With prescaler assign set the timer runs at 1:1 and the watchdog owns the prescaler.
// - Software has no read or write path to the prescaler counter.
// - A count register write clears the prescaler while it belongs to the timer.
// - Rollover from FFh to 00h sets the overflow flag, which only software clears.
// - In counter mode the input is sampled on the second and fourth phase clocks.
// - During sleep counting stops and the count is held.
module tmc_timer8
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_COUNT_IN,
	output logic WATCHDOG_PRESCALER_OWN,
	output logic IRQ
);
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] option_r;
	logic [7:0] mask_r;
	logic ovf_r;
	logic sleep_r;
	logic [1:0] hold_r;
	tmc_pkg::tmc_phase_t phase_r;
	logic [31:0] rdata_r;

	logic wr;
	logic wr_count;
	logic wr_option;
	logic wr_status;
	logic wr_mask;
	logic wr_ctrl;
	logic hit;
	logic instr_pulse;
	logic sample_pt;
	logic ext_edge;
	logic src_pulse;
	logic inc;
	logic roll;
	logic cs;
	logic se;
	logic wd_owns;
	logic [2:0] ratio_sel;
	logic [31:0] rd_mux;

	// Per-register select lines and read words
	logic rd_setup;
	logic sel_count;
	logic sel_option;
	logic sel_status;
	logic sel_mask;
	logic sel_ctrl;
	logic [31:0] word_count;
	logic [31:0] word_option;
	logic [31:0] word_status;
	logic [31:0] word_mask;
	logic [31:0] word_ctrl;

	// Next values of the software registers
	logic hold_busy;
	logic [1:0] hold_nxt;
	logic [7:0] option_nxt;
	logic [7:0] mask_nxt;
	logic sleep_nxt;

	// Tick path between prescaler and count register
	tmc_tick_if tk ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Exact word match of the bus address against one register offset
	function automatic logic addr_is(input logic [11:0] addr,
		input logic [11:0] offs);
		return addr == offs;
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero-wait slave; unmapped addresses report an error
	assign wr = PSEL & PENABLE & PWRITE;
	// Reads are captured in the setup phase, one edge ahead of the access
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

	// One select line per register word
	assign sel_count = addr_is(PADDR, tmc_pkg::ADDR_COUNT);
	assign sel_option = addr_is(PADDR, tmc_pkg::ADDR_OPTION);
	assign sel_status = addr_is(PADDR, tmc_pkg::ADDR_STATUS);
	assign sel_mask = addr_is(PADDR, tmc_pkg::ADDR_MASK);
	assign sel_ctrl = addr_is(PADDR, tmc_pkg::ADDR_CTRL);
	assign hit = sel_count | sel_option | sel_status | sel_mask | sel_ctrl;

	// Write strobes, live only in the access phase
	assign wr_count = wr & sel_count;
	assign wr_option = wr & sel_option;
	assign wr_status = wr & sel_status;
	assign wr_mask = wr & sel_mask;
	assign wr_ctrl = wr & sel_ctrl;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;

	// Register words as a read returns them, unused bits zero
	assign word_count = {24'h000000, count_r};
	assign word_option = {24'h000000, option_r};
	assign word_status = {31'h00000000, ovf_r};
	assign word_mask = {24'h000000, mask_r};
	assign word_ctrl = {31'h00000000, sleep_r};

	// Read multiplexer; prescaler counter has no address
	assign rd_mux =
		sel_count ? word_count :
		sel_option ? word_option :
		sel_status ? word_status :
		sel_mask ? word_mask :
		sel_ctrl ? word_ctrl :
		32'h00000000;

	// Read data from a flip-flop: loaded in the setup phase, it stands
	// through the access phase and keeps the last read word afterwards;
	// a count that moves on the setup edge shows up on the next read
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			rdata_r <= 32'h00000000;
		else if (rd_setup)
			rdata_r <= rd_mux;
	end
	assign PRDATA = rdata_r;

	// ----------------------------------------------------------------
	// Option fields
	// ----------------------------------------------------------------
	assign cs = option_r[tmc_pkg::OPT_CS_BIT];
	assign se = option_r[tmc_pkg::OPT_SE_BIT];
	assign wd_owns = option_r[tmc_pkg::OPT_ASSIGN_BIT];
	assign ratio_sel = option_r[tmc_pkg::OPT_RATIO_LSB +: 3];
	// Owner flag for the watchdog side; a set bit bypasses the prescaler
	assign WATCHDOG_PRESCALER_OWN = wd_owns;

	// ----------------------------------------------------------------
	// Instruction phase clock Q1..Q4
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			phase_r <= tmc_pkg::PH_Q1;
		else
		begin
			case (phase_r)
				tmc_pkg::PH_Q1: phase_r <= tmc_pkg::PH_Q2;
				tmc_pkg::PH_Q2: phase_r <= tmc_pkg::PH_Q3;
				tmc_pkg::PH_Q3: phase_r <= tmc_pkg::PH_Q4;
				default: phase_r <= tmc_pkg::PH_Q1;
			endcase
		end
	end
	assign instr_pulse = (phase_r == tmc_pkg::PH_Q4);
	assign sample_pt = (phase_r == tmc_pkg::PH_Q2) |
		(phase_r == tmc_pkg::PH_Q4);

	// ----------------------------------------------------------------
	// Clock source and prescaler
	// ----------------------------------------------------------------
	tmc_edge_sync u_sync (
		.clk(SYS_CLK),
		.rst(RESET),
		.pin(EXT_COUNT_IN),
		.sample_en(sample_pt),
		.falling(se),
		.edge_pulse(ext_edge)
	);

	// Counter mode when select is set, timer mode when clear
	assign src_pulse = ~sleep_r &
		(cs ? ext_edge : instr_pulse);
	// Prescaler restarts on a count write only while the timer owns it
	assign tk.clear = wr_count & ~wd_owns;

	tmc_prescaler u_psc (
		.clk(SYS_CLK),
		.rst(RESET),
		.src_pulse(src_pulse),
		.to_timer(~wd_owns),
		.ratio(ratio_sel),
		.tk(tk)
	);

	// ----------------------------------------------------------------
	// Count register
	// ----------------------------------------------------------------
	// Increments are dropped while the post-write hold runs or asleep
	// A write in the same cycle wins over a tick, so no false rollover
	assign hold_busy = (hold_r != 2'd0);
	assign inc = tk.tick & ~hold_busy & ~sleep_r & ~wr_count;
	assign roll = inc & (count_r == 8'hFF);
	assign count_nxt = wr_count ? PWDATA[7:0] :
		(inc ? count_r + 8'h01 : count_r);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			count_r <= tmc_pkg::COUNT_RESET;
		else
			count_r <= count_nxt;
	end

	// Hold counts down on instruction-cycle boundaries after a write;
	// a second write restarts it, so close writes never count early
	assign hold_nxt = wr_count ? 2'(tmc_pkg::WRITE_HOLD_CYC) :
		((instr_pulse & hold_busy) ? hold_r - 2'd1 : hold_r);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			hold_r <= 2'd0;
		else
			hold_r <= hold_nxt;
	end

	// ----------------------------------------------------------------
	// Option, mask, sleep control
	// ----------------------------------------------------------------
	// Next values: a write replaces the byte, otherwise it is kept
	assign option_nxt = wr_option ? PWDATA[7:0] : option_r;
	assign mask_nxt = wr_mask ? PWDATA[7:0] : mask_r;
	assign sleep_nxt = wr_ctrl ? PWDATA[tmc_pkg::CTRL_SLEEP_BIT] : sleep_r;

	// Option byte; reset hands the prescaler to the watchdog
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			option_r <= tmc_pkg::OPTION_RESET;
		else
			option_r <= option_nxt;
	end

	// Interrupt mask byte
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			mask_r <= tmc_pkg::MASK_RESET;
		else
			mask_r <= mask_nxt;
	end

	// Sleep control; while set the count and prescaler stand still
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			sleep_r <= tmc_pkg::SLEEP_RESET;
		else
			sleep_r <= sleep_nxt;
	end

	// ----------------------------------------------------------------
	// Overflow flag and interrupt
	// ----------------------------------------------------------------
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			ovf_r <= 1'b0;
		else if (roll)
			ovf_r <= 1'b1;
		else if (wr_status && PWDATA[tmc_pkg::STAT_OVF_BIT])
			ovf_r <= 1'b0;
	end

	// Flag sets regardless of enable; mask only gates the output
	assign IRQ = ovf_r & mask_r[tmc_pkg::STAT_OVF_BIT];
endmodule

/* File: verification/tmc_timer8_assertions.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker of the timer block
// ------------------------------------------------
module tmc_timer8_assertions
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic EXT_COUNT_IN,
	input wire logic WATCHDOG_PRESCALER_OWN,
	input wire logic IRQ
);
	// Access phase decode
	wire acc = PSEL && PENABLE;
	wire rd = acc && !PWRITE;
	wire mapped = PADDR[1:0] == 2'h0 && PADDR <= 12'h010;
	wire stat_rd = rd && PADDR == tmc_pkg::ADDR_STATUS;
	wire opt_wr = acc && PWRITE && PADDR == tmc_pkg::ADDR_OPTION;

	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);

	a_zero_wait: assert property (acc |-> PREADY)
		else $error("no ready in access");
	a_err_map: assert property (acc |-> PSLVERR == !mapped)
		else $error("error flag wrong");
	a_err_idle: assert property (!acc |-> !PSLVERR)
		else $error("error flag outside access");
	a_unmapped_zero: assert property (rd && !mapped |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (rd |-> PRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	a_irq_flag: assert property (stat_rd && !PRDATA[0] |-> !$past(IRQ))
		else $error("irq without flag");
	a_owner_follows: assert property
		(opt_wr |=> WATCHDOG_PRESCALER_OWN == $past(PWDATA[3]))
		else $error("owner not updated");
	a_reset_state: assert property
		($fell(RESET) |-> !IRQ && WATCHDOG_PRESCALER_OWN)
		else $error("bad state after reset");

	// Main scenarios
	c_irq: cover property ($rose(IRQ));
	c_counter: cover property (opt_wr && PWDATA[5]);
	c_unmapped: cover property (acc && !mapped);
endmodule

bind tmc_timer8 tmc_timer8_assertions i_chk
(
	.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.PRDATA, .PREADY, .PSLVERR, .EXT_COUNT_IN, .WATCHDOG_PRESCALER_OWN, .IRQ
);

/* File: verification/tmc_ext_src.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// External count source
// ------------------------------------------------
module tmc_ext_src
(
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;

	// New level, held over several instruction cycles
	task automatic set_level(input logic lvl);
		@(posedge clk);
		pin <= lvl;
		repeat (16) @(posedge clk);
	endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(x, y) \
	begin \
		check_count++; \
		if ((x) !== (y)) \
		begin \
			err_count++; \
			$display("MISMATCH %0t got %h want %h", $time, (x), (y)); \
		end \
	end
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic own;
	logic irq;
	logic [31:0] rdata;
	logic rerr;
	logic [7:0] base;
	int err_count = 0;
	int check_count = 0;

	// Clock
	always #5 clk = ~clk;

	tmc_timer8 i_dut
	(
		.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .EXT_COUNT_IN(pin),
		.WATCHDOG_PRESCALER_OWN(own), .IRQ(irq)
	);
	tmc_ext_src i_src (.clk(clk), .pin(pin));

	// Verdict and end of run
	task automatic conclude();
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer, bounded wait for ready
	task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			err_count++;
			conclude();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Count gain between two reads spaced gap+3 cycles
	task automatic span(input int gap, input logic [7:0] exp);
		logic [7:0] first;
		apb(1'b0, 12'h000, 8'h00);
		first = rdata[7:0];
		repeat (gap) @(posedge clk);
		apb(1'b0, 12'h000, 8'h00);
		`CHK(rdata[7:0] - first, exp)
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, 12'(i * 4), 8'h00);
			`CHK(rdata, (i == 1) ? 32'h3F : 32'h0)
		end
		apb(1'b0, 12'h014, 8'h00);
		`CHK({rerr, rdata}, 33'h100000000)
		apb(1'b1, 12'h004, 8'h08);
		`CHK(own, 1'b1)
		span(37, 8'h0A);
		apb(1'b1, 12'h000, 8'h55);
		apb(1'b0, 12'h000, 8'h00);
		`CHK(rdata, 32'h55)
		repeat (34) @(posedge clk);
		apb(1'b0, 12'h000, 8'h00);
		`CHK(rdata[7:0] inside {8'h5C, 8'h5D}, 1'b1)
		apb(1'b1, 12'h010, 8'h01);
		span(37, 8'h00);
		apb(1'b1, 12'h010, 8'h00);
		apb(1'b1, 12'h00C, 8'h01);
		apb(1'b1, 12'h000, 8'hFE);
		repeat (30) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1'b1, 12'h00C, 8'h00);
		`CHK(irq, 1'b0)
		apb(1'b0, 12'h008, 8'h00);
		`CHK(rdata, 32'h1)
		apb(1'b1, 12'h008, 8'h01);
		apb(1'b0, 12'h008, 8'h00);
		`CHK(rdata, 32'h0)
		for (int n = 0; n < 8; n++)
		begin
			apb(1'b1, 12'h004, 8'(n));
			`CHK(own, 1'b0)
			repeat (8) @(posedge clk);
			span((8 << n) - 3, 8'h01);
		end
		repeat (4)
		begin
			apb(1'b1, 12'h000, 8'h20);
			repeat (20) @(posedge clk);
			apb(1'b0, 12'h000, 8'h00);
			`CHK(rdata, 32'h20)
		end
		for (int se = 0; se < 2; se++)
		begin
			apb(1'b1, 12'h004, se ? 8'h38 : 8'h28);
			apb(1'b0, 12'h000, 8'h00);
			base = rdata[7:0];
			i_src.set_level(1'b1);
			apb(1'b0, 12'h000, 8'h00);
			`CHK(rdata[7:0] - base, 8'(1 - se))
			i_src.set_level(1'b0);
			apb(1'b0, 12'h000, 8'h00);
			`CHK(rdata[7:0] - base, 8'h01)
		end
		conclude();
	end
endmodule
